// [pscs_defs.vh]
// constants for the power-stage control-source and supply supervisor
`ifndef PSCS_DEFS_VH
`define PSCS_DEFS_VH

// ==========================================================
// frame
`define PSCS_FRAME_BITS 16
`define PSCS_HOLD_RST 16'hffff
`define PSCS_TEST_BIT 8

// ==========================================================
// supply status/config register fields
`define PSCS_SC_OV_OK 0
`define PSCS_SC_UV_OK 1
`define PSCS_SC_PIN 2
`define PSCS_SC_DIAG_OK 3
`define PSCS_SC_OT_OK 4
`define PSCS_SC_OV_LATCH 5
`define PSCS_SC_THR_LOWER 6
`define PSCS_SC_TEST_OFF 7
`define PSCS_SC_CFG_RST 3'h7
`define PSCS_INP1_TEST 6

// ==========================================================
// timing
`define PSCS_CLK_PERIOD_NS 4
`define PSCS_FILT_TIME_NS 20000

`endif

// [pscs_frame_rx.v]
// fast serial frame receiver: shift on frame clock, latch on sync edge
`timescale 1ns/1ps
`include "pscs_defs.vh"
module pscs_frame_rx #(
  parameter NBITS = `PSCS_FRAME_BITS
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire data_s,
  input wire clk_s,
  input wire sync_s,
  output wire [NBITS-1:0] hold,
  output wire latch_pulse
);
  reg clk_d_ff;
  reg sync_d_ff;
  reg [NBITS-1:0] shift_ff;
  reg [NBITS-1:0] hold_ff;
  wire clk_rise;
  wire sync_rise;

  assign clk_rise = clk_s & ~clk_d_ff;
  assign sync_rise = sync_s & ~sync_d_ff;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_d_ff <= 1'b0;
      sync_d_ff <= 1'b0;
      shift_ff <= `PSCS_HOLD_RST;
      hold_ff <= `PSCS_HOLD_RST;
    end else if (clk_en) begin
      clk_d_ff <= clk_s;
      sync_d_ff <= sync_s;
      // D0 arrives first and ends in bit 0 after sixteen pulses; no frame check
      if (clk_rise) begin
        shift_ff <= {data_s, shift_ff[NBITS-1:1]};
      end
      if (sync_rise) begin
        hold_ff <= shift_ff;
      end
    end
  end

  assign hold = hold_ff;
  assign latch_pulse = sync_rise & clk_en;
endmodule

// [pscs_mcu_model.sv]
// controller side of the fast serial link: frame data, frame clock, sync
`timescale 1ns/1ps
module pscs_mcu_model (
  output logic fdat,
  output logic fclk,
  output logic fsync
);
  initial begin
    fdat = 1'b0;
    fclk = 1'b0;
    fsync = 1'b0;
  end
  // frame clock stands low between frames; data moves only while it is low
  task automatic send_frame(input logic [15:0] w, input logic do_sync, input int hp);
    for (int i = 0; i < 16; i++) begin
      fdat = w[i];
      #(hp);
      fclk = 1'b1;
      #(hp);
      fclk = 1'b0;
    end
    // no pull on the data line: park it inverted so a stale bit is never trusted
    fdat = ~w[15];
    #(hp);
    if (do_sync) begin
      fsync = 1'b1;
      #(2 * hp);
      fsync = 1'b0;
      #(hp);
    end
  endtask
endmodule

// [pscs_properties.sv]
// port-level assertions for the supervisor top
`timescale 1ns/1ps
module pscs_properties #(
  parameter FILT_CYC = 8
) (
  input logic core_clk,
  input logic reset_n,
  input logic rst_pin_n,
  input logic vdd_uv_raw,
  input logic vdd_ov_raw,
  input logic statcon_wr,
  input logic [7:0] statcon_wdata,
  input logic shutdown_pin_out,
  input logic shutdown_pin_oe,
  input logic [7:0] supply_status_config,
  input logic [15:0] stage_on,
  input logic diag_record_en
);
  // stage 8 has its own supply path, so it is masked out of the bus-stage checks
  localparam logic [15:0] stage_mask = 16'hff7f;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // assertions
  AST_RST_OFF: assert property (!rst_pin_n [*6] |-> (stage_on & stage_mask) == 16'h0000)
    else $error("stage on while reset pin low");
  AST_UV_OE: assert property (vdd_uv_raw [*5] |-> shutdown_pin_oe)
    else $error("undervoltage without pin pull");
  AST_OV_OFF: assert property (vdd_ov_raw [*6] |-> (stage_on & stage_mask) == 16'h0000)
    else $error("stage on during overvoltage");
  AST_UV_STAT: assert property (vdd_uv_raw [*6] |-> !supply_status_config[1])
    else $error("undervoltage status not shown");
  AST_OV_STAT: assert property (vdd_ov_raw [*6] |-> !supply_status_config[0])
    else $error("overvoltage status not shown");
  AST_CFG_WR: assert property (statcon_wr |-> ##2 supply_status_config[7:5] == $past(statcon_wdata[7:5], 2))
    else $error("config bits not written");
  AST_PIN_DRV: assert property (shutdown_pin_oe |-> !shutdown_pin_out)
    else $error("shutdown pin driven high");
  AST_NO_DIAG: assert property (shutdown_pin_oe [*2] |-> !diag_record_en)
    else $error("diagnostics recorded during shut-off");
  AST_UV_HOLD: assert property (vdd_uv_raw [*6] ##1 !vdd_uv_raw |-> ##FILT_CYC shutdown_pin_oe)
    else $error("pin released before filter time");
  // ==========================================================
  // covers
  cover property ($fell(shutdown_pin_oe));
  cover property (statcon_wr);
  cover property ($changed(stage_on));
endmodule

// [pscs_sync2.v]
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pscs_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// [pscs_top.v]
// power-stage control-source selection and supply supervision
`timescale 1ns/1ps
`include "pscs_defs.vh"
module pscs_top #(
  parameter FILT_NS = `PSCS_FILT_TIME_NS,
  parameter CLK_NS = `PSCS_CLK_PERIOD_NS,
  parameter FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  // external reset pin of the device, active low
  input wire rst_pin_n,
  // fast serial bus pins
  input wire frame_data_in,
  input wire frame_clock_in,
  input wire frame_sync_in,
  // parallel input pins, index 0 is input 1; bit 7 is parallel_input_eight
  input wire [15:0] par_in,
  // configuration from the register interface, same clock
  input wire bus_source_select,
  input wire source_mux_regs,
  input wire stage8_par_sel,
  input wire cfg_update,
  input wire [15:0] spi_stage_on,
  // supply comparators, asynchronous, high when the condition is present
  input wire vdd_uv_raw,
  input wire vdd_ov_raw,
  input wire vdd_uv_test_raw,
  input wire vdd_ov_test_raw,
  input wire vdd_below35_raw,
  // bidirectional shutdown pin, active low
  input wire shutdown_pin_in,
  output wire shutdown_pin_out,
  output wire shutdown_pin_oe,
  // supply status/config register access
  input wire statcon_wr,
  input wire [7:0] statcon_wdata,
  input wire diag_none_ok,
  input wire diag_ot_ok,
  output wire [7:0] supply_status_config,
  output wire [7:0] input_status_one,
  // power stage controls, index 0 is stage 1, high switches the stage on
  output wire [15:0] stage_on,
  output wire diag_record_en
);
  localparam CW = 16;

  // ==========================================================
  // source states
  localparam [1:0] SRC_SPI = 2'h0;
  localparam [1:0] SRC_PAR = 2'h1;
  localparam [1:0] SRC_BUS = 2'h2;

  // ==========================================================
  // frame bit feeding each stage; 8 means none
  function [3:0] frame_bit_of;
    input integer stage;
    begin
      case (stage)
        1: frame_bit_of = 4'h1;
        2: frame_bit_of = 4'h2;
        3: frame_bit_of = 4'h3;
        4: frame_bit_of = 4'h4;
        5: frame_bit_of = 4'h5;
        6: frame_bit_of = 4'h6;
        7: frame_bit_of = 4'h7;
        9: frame_bit_of = 4'hb;
        10: frame_bit_of = 4'ha;
        11: frame_bit_of = 4'h9;
        12: frame_bit_of = 4'hc;
        13: frame_bit_of = 4'hd;
        14: frame_bit_of = 4'h0;
        15: frame_bit_of = 4'hf;
        16: frame_bit_of = 4'he;
        default: frame_bit_of = 4'h8;
      endcase
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  wire [2:0] fr_s;
  wire [15:0] par_s;
  wire [5:0] sup_s;
  wire rst_pin_s;
  wire pin_s;

  pscs_sync2 #(.WIDTH(3), .RST_VAL(3'h0)) u_sync_frame (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in({frame_sync_in, frame_clock_in, frame_data_in}),
    .sync_out(fr_s)
  );

  pscs_sync2 #(.WIDTH(16), .RST_VAL(16'hffff)) u_sync_par (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(par_in),
    .sync_out(par_s)
  );

  // supply faults other than the main overvoltage input come up asserted so nothing switches on before the first sample
  pscs_sync2 #(.WIDTH(6), .RST_VAL(6'h3d)) u_sync_sup (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in({rst_pin_n, vdd_below35_raw, vdd_ov_test_raw, vdd_uv_test_raw, vdd_ov_raw, vdd_uv_raw}),
    .sync_out(sup_s)
  );

  pscs_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_pin (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(shutdown_pin_in),
    .sync_out(pin_s)
  );

  assign rst_pin_s = sup_s[5];

  // ==========================================================
  // frame receiver
  wire [15:0] hold;

  pscs_frame_rx #(.NBITS(`PSCS_FRAME_BITS)) u_rx (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .data_s(fr_s[0]),
    .clk_s(fr_s[1]),
    .sync_s(fr_s[2]),
    .hold(hold),
    .latch_pulse()
  );

  // ==========================================================
  // supply status/config bits 7..5
  reg [2:0] cfg_ff;
  wire test_on;
  wire uv_det;
  wire ov_det;
  wire below35;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= `PSCS_SC_CFG_RST;
    end else if (clk_en && statcon_wr) begin
      cfg_ff <= statcon_wdata[7:5];
    end
  end

  // threshold test swaps in the shifted comparator for the selected side
  assign test_on = ~cfg_ff[`PSCS_SC_TEST_OFF - 5];
  assign uv_det = (test_on & cfg_ff[`PSCS_SC_THR_LOWER - 5]) ? sup_s[2] : sup_s[0];
  assign ov_det = (test_on & ~cfg_ff[`PSCS_SC_THR_LOWER - 5]) ? sup_s[3] : sup_s[1];
  assign below35 = sup_s[4];

  // ==========================================================
  // stored overvoltage: set dominates, survives the reset pin
  reg ov_store_ff;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ov_store_ff <= 1'b0;
    end else if (clk_en) begin
      if (ov_det) begin
        ov_store_ff <= 1'b1;
      end else if (below35 || !cfg_ff[`PSCS_SC_OV_LATCH - 5]) begin
        ov_store_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // shutdown pin drive and recovery filter
  reg [CW-1:0] filt_cnt_ff;
  reg pull_low_ff;
  wire fault_now;
  wire ov_held;
  wire filt_done;

  assign ov_held = ov_store_ff & cfg_ff[`PSCS_SC_OV_LATCH - 5];
  assign fault_now = uv_det | ov_det | ov_held;
  assign filt_done = (filt_cnt_ff == {CW{1'b0}});

  // counter reloads on every fault sample, so a chattering supply never releases the pin
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_cnt_ff <= FILT_CYC[CW-1:0];
    end else if (clk_en) begin
      if (fault_now) begin
        filt_cnt_ff <= FILT_CYC[CW-1:0];
      end else if (!filt_done) begin
        filt_cnt_ff <= filt_cnt_ff - 1'b1;
      end
    end
  end

  // pin pull starts at once on a fault and ends only once the filter has run out
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pull_low_ff <= 1'b1;
    end else if (clk_en) begin
      if (fault_now) begin
        pull_low_ff <= 1'b1;
      end else if (filt_done) begin
        pull_low_ff <= 1'b0;
      end
    end
  end

  assign shutdown_pin_out = 1'b0;
  assign shutdown_pin_oe = pull_low_ff;

  // ==========================================================
  // control source, held on the register interface after a reset pin pulse
  reg spi_lock_ff;
  reg [1:0] src_ff;
  reg [1:0] nxt_src;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      spi_lock_ff <= 1'b1;
    end else if (clk_en) begin
      if (!rst_pin_s) begin
        spi_lock_ff <= 1'b1;
      end else if (cfg_update) begin
        spi_lock_ff <= 1'b0;
      end
    end
  end

  always @* begin
    nxt_src = SRC_SPI;
    if (!spi_lock_ff && source_mux_regs) begin
      nxt_src = bus_source_select ? SRC_PAR : SRC_BUS;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_ff <= SRC_SPI;
    end else if (clk_en) begin
      src_ff <= nxt_src;
    end
  end

  // ==========================================================
  // stage drive; the monitor only gates outputs, it never rewrites registers
  wire supply_off;
  wire pin_low;
  wire monitor_off;
  wire [15:0] want_on;

  // own comparators act directly, so a pin shorted high cannot keep stages on
  assign pin_low = ~pin_s;
  assign monitor_off = pull_low_ff | uv_det | ov_det;
  assign supply_off = monitor_off | pin_low;

  genvar gi;
  generate
    for (gi = 1; gi <= 16; gi = gi + 1) begin : g_stage
      if (gi == 8) begin : g_eight
        // inverting parallel path, kept alive through reset and normal undervoltage
        assign want_on[7] = stage8_par_sel ?
          (~par_s[7] & ~below35 & ~ov_det & ~ov_held) :
          (spi_stage_on[7] & ~supply_off & rst_pin_s);
      end else begin : g_other
        reg sel_on;
        always @* begin
          case (src_ff)
            SRC_BUS: sel_on = ~hold[frame_bit_of(gi)];
            SRC_PAR: sel_on = par_s[gi-1];
            default: sel_on = spi_stage_on[gi-1];
          endcase
        end
        assign want_on[gi-1] = sel_on & rst_pin_s & ~supply_off;
      end
    end
  endgenerate

  reg [15:0] stage_on_ff;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_on_ff <= 16'h0000;
    end else if (clk_en) begin
      stage_on_ff <= want_on;
    end
  end

  assign stage_on = stage_on_ff;

  // ==========================================================
  // readback and diagnostic gating
  reg [7:0] status_ff;
  reg [7:0] inp1_ff;
  reg diag_en_ff;
  reg [7:0] nxt_status;
  reg [7:0] nxt_inp1;

  // config bits read back as written; bit 0 also shows the stored overvoltage
  always @* begin
    nxt_status = 8'h00;
    nxt_status[7:5] = cfg_ff;
    nxt_status[`PSCS_SC_OT_OK] = diag_ot_ok;
    nxt_status[`PSCS_SC_DIAG_OK] = diag_none_ok;
    nxt_status[`PSCS_SC_PIN] = pin_s;
    nxt_status[`PSCS_SC_UV_OK] = ~uv_det;
    nxt_status[`PSCS_SC_OV_OK] = ~(ov_det | ov_store_ff);
  end

  // input pins are shown live, not latched; input eight reads inverted
  always @* begin
    nxt_inp1 = 8'h00;
    nxt_inp1[7] = ~par_s[7];
    nxt_inp1[`PSCS_INP1_TEST] = hold[`PSCS_TEST_BIT];
    nxt_inp1[5] = 1'b0;
    nxt_inp1[4:0] = par_s[4:0];
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= 8'he0;
      inp1_ff <= 8'h40;
      diag_en_ff <= 1'b0;
    end else if (clk_en) begin
      status_ff <= nxt_status;
      inp1_ff <= nxt_inp1;
      diag_en_ff <= ~supply_off;
    end
  end

  assign supply_status_config = status_ff;
  assign input_status_one = inp1_ff;
  assign diag_record_en = diag_en_ff;
endmodule

// [testbench.sv]
// self-checking bench: frames, source select, supply monitor, self-test
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] mask = 16'hff7f;
  logic core_clk, reset_n = 1'b0, clk_en = 1'b1, rst_pin_n = 1'b1, bus_source_select = 1'b0;
  logic source_mux_regs = 1'b1, stage8_par_sel = 1'b0, cfg_update = 1'b0, ext_low = 1'b0;
  logic vdd_uv_raw = 1'b0, vdd_ov_raw = 1'b0, vdd_uv_test_raw = 1'b0, vdd_ov_test_raw = 1'b0;
  logic vdd_below35_raw = 1'b0, statcon_wr = 1'b0, diag_none_ok = 1'b1, diag_ot_ok = 1'b1;
  logic [15:0] par_in = 16'h0000, spi_stage_on = 16'h00ff;
  logic [7:0] statcon_wdata = 8'h00;
  wire shutdown_pin_out, shutdown_pin_oe, diag_record_en, fdat, fclk, fsync;
  wire [7:0] supply_status_config, input_status_one;
  wire [15:0] stage_on;
  int mismatches, n_compared;
  pscs_top #(.FILT_CYC(8)) u_pscs_top (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .rst_pin_n(rst_pin_n), .frame_data_in(fdat), .frame_clock_in(fclk), .frame_sync_in(fsync),
    .par_in(par_in), .bus_source_select(bus_source_select), .source_mux_regs(source_mux_regs),
    .stage8_par_sel(stage8_par_sel), .cfg_update(cfg_update), .spi_stage_on(spi_stage_on),
    .vdd_uv_raw(vdd_uv_raw), .vdd_ov_raw(vdd_ov_raw), .vdd_uv_test_raw(vdd_uv_test_raw),
    .vdd_ov_test_raw(vdd_ov_test_raw), .vdd_below35_raw(vdd_below35_raw),
    .shutdown_pin_in(!shutdown_pin_oe && !ext_low), .shutdown_pin_out(shutdown_pin_out),
    .shutdown_pin_oe(shutdown_pin_oe), .statcon_wr(statcon_wr), .statcon_wdata(statcon_wdata),
    .diag_none_ok(diag_none_ok), .diag_ot_ok(diag_ot_ok), .supply_status_config(supply_status_config),
    .input_status_one(input_status_one), .stage_on(stage_on), .diag_record_en(diag_record_en));
  pscs_mcu_model u_mcu (.fdat(fdat), .fclk(fclk), .fsync(fsync));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ==========================================================
  // helpers
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wait_oe(input logic v);
    int i;
    for (i = 0; i < 200 && shutdown_pin_oe !== v; i++) cyc(1);
    chk(shutdown_pin_oe, v);
    if (shutdown_pin_oe !== v) final_report();
  endtask
  // low bits carry junk on purpose: only bits 7..5 are stored
  task wr(input logic [2:0] c);
    statcon_wr = 1'b1;
    statcon_wdata = {c, 5'h1f};
    cyc(1);
    statcon_wr = 1'b0;
    cyc(2);
  endtask
  function automatic logic [15:0] exp_on(input logic [15:0] w);
    return ~{w[14], w[15], w[0], w[13], w[12], w[9], w[10], w[11], 1'b1, w[7:1]};
  endfunction
  // ==========================================================
  // scenarios
  task t_reset;
    wait_oe(0);
    cyc(4);
    chk(stage_on, spi_stage_on);
    chk(supply_status_config[7:5], 3'h7);
    chk(input_status_one[6], 1'b1);
    cfg_update = 1'b1;
    cyc(1);
    cfg_update = 1'b0;
    cyc(6);
    chk(stage_on & mask, 16'h0000);
  endtask
  task t_frames;
    logic [15:0] words [4] = '{16'h0000, 16'hfeff, 16'h5a3c, 16'hffff};
    u_mcu.send_frame(16'h1234, 1'b0, 80);
    cyc(6);
    chk(stage_on & mask, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      u_mcu.send_frame(words[i], 1'b1, (i == 2) ? 200 : 80);
      cyc(6);
      chk(stage_on & mask, exp_on(words[i]) & mask);
      chk(input_status_one[6], words[i][8]);
    end
    // a frame sent while the clock enable is low must leave no trace
    clk_en = 1'b0;
    u_mcu.send_frame(16'h0000, 1'b1, 80);
    clk_en = 1'b1;
    cyc(6);
    chk(stage_on & mask, 16'h0000);
  endtask
  task t_par;
    bus_source_select = 1'b1;
    par_in = 16'ha55a;
    stage8_par_sel = 1'b1;
    cyc(8);
    chk(stage_on & mask, 16'ha55a & mask);
    rst_pin_n = 1'b0;
    cyc(8);
    chk(stage_on, 16'h0080);
    rst_pin_n = 1'b1;
    vdd_uv_raw = 1'b1;
    cyc(8);
    chk(stage_on, 16'h0080);
    vdd_below35_raw = 1'b1;
    cyc(8);
    chk(stage_on, 16'h0000);
    vdd_uv_raw = 1'b0;
    vdd_below35_raw = 1'b0;
    wait_oe(0);
    ext_low = 1'b1;
    cyc(8);
    chk(stage_on & mask, 16'h0000);
    chk(supply_status_config[2], 1'b0);
    chk(diag_record_en, 1'b0);
    ext_low = 1'b0;
  endtask
  task t_supply;
    vdd_ov_raw = 1'b1;
    diag_none_ok = 1'b0;
    wait_oe(1);
    wr(3'h6);
    chk(supply_status_config[0], 1'b0);
    chk(supply_status_config[4:3], 2'h2);
    wr(3'h7);
    rst_pin_n = 1'b0;
    cyc(8);
    rst_pin_n = 1'b1;
    vdd_ov_raw = 1'b0;
    cyc(30);
    chk(shutdown_pin_oe, 1'b1);
    chk(supply_status_config[0], 1'b0);
    wr(3'h6);
    wait_oe(0);
    chk(supply_status_config[0], 1'b1);
    diag_none_ok = 1'b1;
    cyc(3);
    chk(supply_status_config[3], 1'b1);
    wr(3'h7);
    vdd_uv_raw = 1'b1;
    wait_oe(1);
    chk(supply_status_config[1], 1'b0);
    vdd_uv_raw = 1'b0;
    cyc(4);
    chk(shutdown_pin_oe, 1'b1);
    wait_oe(0);
  endtask
  task t_selftest;
    vdd_ov_test_raw = 1'b1;
    vdd_uv_test_raw = 1'b1;
    wr(3'h0);
    chk(supply_status_config[7:5], 3'h0);
    cyc(4);
    chk(supply_status_config[0], 1'b0);
    wr(3'h6);
    cyc(4);
    chk(supply_status_config[0], 1'b1);
    wr(3'h2);
    cyc(4);
    chk(supply_status_config[1], 1'b0);
    wr(3'h6);
    cyc(4);
    chk(supply_status_config[1], 1'b1);
    wr(3'h7);
    vdd_ov_test_raw = 1'b0;
    vdd_uv_test_raw = 1'b0;
    wait_oe(0);
  endtask
  initial begin
    cyc(4);
    reset_n = 1'b1;
    t_reset();
    t_frames();
    t_par();
    t_supply();
    t_selftest();
    final_report();
  end
endmodule
bind pscs_top pscs_properties #(.FILT_CYC(FILT_CYC)) u_pscs_properties (.core_clk(core_clk),
  .reset_n(reset_n), .rst_pin_n(rst_pin_n), .vdd_uv_raw(vdd_uv_raw), .vdd_ov_raw(vdd_ov_raw),
  .statcon_wr(statcon_wr), .statcon_wdata(statcon_wdata), .shutdown_pin_out(shutdown_pin_out),
  .shutdown_pin_oe(shutdown_pin_oe), .supply_status_config(supply_status_config),
  .stage_on(stage_on), .diag_record_en(diag_record_en));
